// >>> logic/rfp_rail_protect.sv
/*
 * Holds the auxiliary rail fault latches, over-current supervisor, gate overrides,
 * fast pulse, straps, current converter and Avalon-MM slave.
 * Assumes comparator levels synchronous to CLK; RESET is the power-on reset.
 */
// Functional notes
// - Capture offset input at enable rise; low disables
// - Strap two enables external rail offset
// - Step up forces two phases; down holds
// - Step compensation bits come from both straps
// - Monitor voltage to 512 codes (0 to 511), 6.25mV each
// - Fast pulse matches on-time, overrides active phases
// - Sustained trip after programmed trigger delay
// - Peak trip on any cycle above limit
// - Either trip asserts flag, starts action delay
// - Still over after delay: all switches off
// - Over-voltage watch starts after power-on threshold
// - Code below 0.9V: trip above 1.225V
// - Code above 0.9V: trip above reference+325mV
// - Over-voltage latch: active-phase low sides on, highs off
// - Over-voltage needs 1us persistence
// - Voltage fault latch forces other rail shutdown
// - Negative sense in latch turns low sides off
// - Negative guard only after over-voltage latched
// - Sense 500mV below reference latches, all off
// - Under-voltage needs 3us persistence
// - Supply under threshold 3us: all off
`timescale 1ns/1ps
`include "rfp_cfg.svh"

module rfp_rail_protect
#(
    parameter int PHASES   = 2,
    parameter int DLY_BITS = 16
)
(
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET,
    // Avalon-MM slave
    input  wire logic [3:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    output logic [31:0]            AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    // Enable, supply and straps
    input  wire logic              ENABLE,
    input  wire logic              SUPPLY_ABOVE_POR,
    input  wire logic              EXTERNAL_OFFSET_INPUT_LOW,
    input  wire logic [1:0]        CONFIG_STRAP_ONE,
    input  wire logic [1:0]        CONFIG_STRAP_TWO,
    // Rail sense comparators
    input  wire logic              VOLTAGE_CODE_BELOW_LIMIT,
    input  wire logic              RAIL_SENSE_ABOVE_FIXED,
    input  wire logic              RAIL_SENSE_ABOVE_REF,
    input  wire logic              RAIL_SENSE_BELOW_REF,
    input  wire logic              RAIL_SENSE_NEGATIVE,
    // Current comparators and monitor sample
    input  wire logic              SUSTAINED_CURRENT_ABOVE,
    input  wire logic              PEAK_CURRENT_ABOVE,
    input  wire logic              SWITCH_CYCLE_STROBE,
    input  wire logic [21:0]       CURRENT_MONITOR_UV,
    // Loop requests
    input  wire logic              STEP_UP,
    input  wire logic              STEP_DOWN,
    input  wire logic              PHASE_SHED_REQ,
    input  wire logic              FAST_LOAD_TRIGGER,
    input  wire logic              ONTIME_REF,
    input  wire logic [PHASES-1:0] PHASE_ACTIVE,
    input  wire logic [PHASES-1:0] PWM_HIGH,
    input  wire logic [PHASES-1:0] PWM_LOW,
    // Gate drive
    output logic [PHASES-1:0]      HIGH_SIDE_ON,
    output logic [PHASES-1:0]      LOW_SIDE_ON,
    // Status and configuration outputs
    output logic                   OVERCURRENT_FLAG_N,
    output logic                   OTHER_RAIL_SHUTDOWN,
    output logic                   TWO_PHASE_FORCE,
    output logic                   INIT_OFFSET_EN,
    output logic                   EXT_OFFSET_EN,
    output logic [1:0]             STEP_COMP_SEL
);

    initial
    begin
        if (PHASES < 1 || PHASES > 2)
            $error("PHASES must be 1 or 2");
        if (DLY_BITS < 8 || DLY_BITS > 32)
            $error("DLY_BITS must be 8 to 32");
    end

    // ----------------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------------

    logic                wait_ff; // Waitrequest register
    logic [31:0]         rdata_ff; // Read data register
    logic [DLY_BITS-1:0] trip_delay_ff; // Sustained trip delay
    logic [DLY_BITS-1:0] act_delay_ff; // Action delay
    logic                req; // A request is present
    logic                wr_take; // Write completes this edge
    logic [31:0]         nxt_rdata; // Read mux output
    logic [31:0]         status_word; // Status image

    assign req     = AVS_READ || AVS_WRITE;
    assign wr_take = AVS_WRITE && !wait_ff;

    // Answer one cycle after the request
    always_ff @(posedge CLK)
    begin
        if (RESET)
            wait_ff <= 1'b1;
        else
            wait_ff <= !(req && wait_ff);
    end

    // Delay registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            trip_delay_ff <= DLY_BITS'(`RFP_TRIP_DELAY_RST);
            act_delay_ff  <= DLY_BITS'(`RFP_ACT_DELAY_RST);
        end
        else if (wr_take && AVS_ADDRESS == `RFP_REG_TRIP_DELAY)
            trip_delay_ff <= AVS_WRITEDATA[DLY_BITS-1:0];
        else if (wr_take && AVS_ADDRESS == `RFP_REG_ACT_DELAY)
            act_delay_ff  <= AVS_WRITEDATA[DLY_BITS-1:0];
    end

    // ----------------------------------------------------------------------
    // Enable edge, straps and offsets
    // ----------------------------------------------------------------------

    logic       en_ff; // Enable delayed one cycle
    logic       en_rise; // Enable rising edge
    logic       init_ofs_ff; // Initial offset enabled
    logic       ext_ofs_ff; // External offset enabled
    logic [1:0] comp_ff; // Step compensation selection

    assign en_rise = ENABLE && !en_ff;

    // Offset input caught at enable rise
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            en_ff       <= 1'b0;
            init_ofs_ff <= 1'b0;
            ext_ofs_ff  <= 1'b0;
            comp_ff     <= 2'h0;
        end
        else
        begin
            en_ff <= ENABLE;
            if (en_rise)
                init_ofs_ff <= !EXTERNAL_OFFSET_INPUT_LOW;
            ext_ofs_ff <= CONFIG_STRAP_TWO[0];
            comp_ff    <= {CONFIG_STRAP_ONE[1], CONFIG_STRAP_TWO[1]};
        end
    end

    // ----------------------------------------------------------------------
    // Voltage faults
    // ----------------------------------------------------------------------

    logic ov_cond; // Raw over-voltage condition
    logic ov_hit; // Over-voltage held 1 us
    logic uv_hit; // Under-voltage held 3 us
    logic lock_hit; // Supply low held 3 us
    logic ov_ff; // Over-voltage latch
    logic uv_ff; // Under-voltage latch
    logic lock_ff; // Supply lockout active
    logic neg_ff; // Negative guard active
    logic latch_clr; // Clears the over- and under-voltage latches

    // Watch above power-on threshold only
    assign ov_cond   = SUPPLY_ABOVE_POR &&
                       (VOLTAGE_CODE_BELOW_LIMIT ? RAIL_SENSE_ABOVE_FIXED
                                                 : RAIL_SENSE_ABOVE_REF);
    assign latch_clr = en_rise;

    rfp_deglitch #(.WIDTH(8)) u_ov_glitch
    (
        .clk   (CLK),
        .reset (RESET),
        .cond  (ov_cond),
        .limit (8'(`RFP_OV_CYCLES)),
        .hit   (ov_hit)
    );

    rfp_deglitch #(.WIDTH(8)) u_uv_glitch
    (
        .clk   (CLK),
        .reset (RESET),
        .cond  (RAIL_SENSE_BELOW_REF),
        .limit (8'(`RFP_UV_CYCLES)),
        .hit   (uv_hit)
    );

    rfp_deglitch #(.WIDTH(8)) u_lock_glitch
    (
        .clk   (CLK),
        .reset (RESET),
        .cond  (!SUPPLY_ABOVE_POR),
        .limit (8'(`RFP_LOCK_CYCLES)),
        .hit   (lock_hit)
    );

    // Voltage latches; a new trip beats the clear
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ov_ff   <= 1'b0;
            uv_ff   <= 1'b0;
            lock_ff <= 1'b0;
            neg_ff  <= 1'b0;
        end
        else
        begin
            ov_ff   <= ov_hit || (ov_ff && !latch_clr);
            uv_ff   <= (uv_hit && SUPPLY_ABOVE_POR) || (uv_ff && !latch_clr);
            lock_ff <= lock_hit || (lock_ff && !SUPPLY_ABOVE_POR);
            // Guard only armed inside the over-voltage latch
            neg_ff  <= ov_ff && RAIL_SENSE_NEGATIVE;
        end
    end

    // ----------------------------------------------------------------------
    // Over-current supervisor
    // ----------------------------------------------------------------------

    rfp_pkg::rfp_oc_state_t oc_state_ff; // Supervisor state
    rfp_pkg::rfp_oc_state_t nxt_oc_state; // Next state
    logic [DLY_BITS-1:0]    act_cnt_ff; // Action delay count
    logic [DLY_BITS-1:0]    nxt_act_cnt; // Next action count
    logic                   sus_hit; // Sustained trip
    logic                   peak_hit; // Peak trip
    logic                   still_over; // Current still over
    logic                   act_done; // Action delay spent

    rfp_deglitch #(.WIDTH(DLY_BITS)) u_sus_glitch
    (
        .clk   (CLK),
        .reset (RESET),
        .cond  (SUSTAINED_CURRENT_ABOVE),
        .limit (trip_delay_ff),
        .hit   (sus_hit)
    );

    assign peak_hit   = SWITCH_CYCLE_STROBE && PEAK_CURRENT_ABOVE;
    assign still_over = SUSTAINED_CURRENT_ABOVE || PEAK_CURRENT_ABOVE;
    assign act_done   = (act_cnt_ff >= act_delay_ff);

    // Trip, action delay, then shut if still over
    always_comb
    begin
        nxt_oc_state = oc_state_ff;
        nxt_act_cnt  = act_cnt_ff;
        case (oc_state_ff)
            rfp_pkg::RFP_OC_IDLE:
            begin
                nxt_act_cnt = '0;
                if (sus_hit || peak_hit)
                    nxt_oc_state = rfp_pkg::RFP_OC_DELAY;
            end
            rfp_pkg::RFP_OC_DELAY:
            begin
                nxt_act_cnt = act_cnt_ff + 1'b1;
                if (act_done)
                    nxt_oc_state = still_over ? rfp_pkg::RFP_OC_SHUT
                                              : rfp_pkg::RFP_OC_IDLE;
            end
            rfp_pkg::RFP_OC_SHUT:
            begin
                // Held until a new enable
                if (latch_clr)
                    nxt_oc_state = rfp_pkg::RFP_OC_IDLE;
            end
            default:
            begin
                nxt_oc_state = rfp_pkg::RFP_OC_IDLE;
            end
        endcase
    end

    // Supervisor registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            oc_state_ff <= rfp_pkg::RFP_OC_IDLE;
            act_cnt_ff  <= '0;
        end
        else
        begin
            oc_state_ff <= nxt_oc_state;
            act_cnt_ff  <= nxt_act_cnt;
        end
    end

    // ----------------------------------------------------------------------
    // Step handling and fast load pulse
    // ----------------------------------------------------------------------

    logic                two_ff; // Two-phase operation forced
    logic                ref_ff; // On-time reference delayed
    logic                trig_ff; // Fast trigger delayed
    logic [DLY_BITS-1:0] ton_meas_ff; // Running on-time
    logic [DLY_BITS-1:0] ton_len_ff; // Last measured on-time
    logic [DLY_BITS-1:0] pulse_cnt_ff; // Remaining pulse cycles
    logic                pulse_on; // Fast pulse active

    assign pulse_on = (pulse_cnt_ff != '0);

    // Step up forces two phases; step down holds
    always_ff @(posedge CLK)
    begin
        if (RESET)
            two_ff <= 1'b0;
        else if (STEP_UP)
            two_ff <= 1'b1;
        else if (PHASE_SHED_REQ && !STEP_DOWN)
            two_ff <= 1'b0;
    end

    // Measure on-time, replay it on a fast trigger
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ref_ff       <= 1'b0;
            trig_ff      <= 1'b0;
            ton_meas_ff  <= '0;
            ton_len_ff   <= DLY_BITS'(1);
            pulse_cnt_ff <= '0;
        end
        else
        begin
            ref_ff      <= ONTIME_REF;
            trig_ff     <= FAST_LOAD_TRIGGER;
            ton_meas_ff <= ONTIME_REF ? ton_meas_ff + 1'b1 : '0;
            if (!ONTIME_REF && ref_ff && ton_meas_ff != '0)
                ton_len_ff <= ton_meas_ff;
            if (FAST_LOAD_TRIGGER && !trig_ff && !pulse_on)
                pulse_cnt_ff <= ton_len_ff;
            else if (pulse_on)
                pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Gate drive overrides
    // ----------------------------------------------------------------------

    logic              all_off; // Every switch forced off
    logic [PHASES-1:0] hs_ff; // High-side drive register
    logic [PHASES-1:0] ls_ff; // Low-side drive register

    assign all_off = lock_ff || uv_ff || (oc_state_ff == rfp_pkg::RFP_OC_SHUT);

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++)
        begin : g_phase
            logic nxt_hs;    // Next high-side state
            logic nxt_ls;    // Next low-side state
            // Off faults, then over-voltage, then normal
            assign nxt_hs = all_off || ov_ff ? 1'b0
                          : (pulse_on && PHASE_ACTIVE[gi]) || PWM_HIGH[gi];
            assign nxt_ls = all_off ? 1'b0
                          : ov_ff ? (PHASE_ACTIVE[gi] && !neg_ff)
                          : PWM_LOW[gi] && !nxt_hs;

            // Phase drive registers
            always_ff @(posedge CLK)
            begin
                if (RESET)
                begin
                    hs_ff[gi] <= 1'b0;
                    ls_ff[gi] <= 1'b0;
                end
                else
                begin
                    hs_ff[gi] <= nxt_hs;
                    ls_ff[gi] <= nxt_ls;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------------
    // Current report converter
    // ----------------------------------------------------------------------

    logic [21:0] adc_quot; // Monitor voltage over one step
    logic [8:0]  nxt_code; // Saturated code
    logic [8:0]  code_ff; // Current reading register

    assign adc_quot = CURRENT_MONITOR_UV / 22'(`RFP_ADC_STEP_UV);
    assign nxt_code = (adc_quot > 22'(`RFP_ADC_MAX_CODE)) ? `RFP_ADC_MAX_CODE : adc_quot[8:0];

    // Conversion register
    always_ff @(posedge CLK)
    begin
        if (RESET)
            code_ff <= 9'h000;
        else
            code_ff <= nxt_code;
    end

    // ----------------------------------------------------------------------
    // Read mux and output registers
    // ----------------------------------------------------------------------

    always_comb
    begin
        status_word                      = 32'h0000_0000;
        status_word[`RFP_ST_OV]          = ov_ff;
        status_word[`RFP_ST_UV]          = uv_ff;
        status_word[`RFP_ST_NEG]         = neg_ff;
        status_word[`RFP_ST_LOCK]        = lock_ff;
        status_word[`RFP_ST_OC_FLAG]     = (oc_state_ff != rfp_pkg::RFP_OC_IDLE);
        status_word[`RFP_ST_OC_SHUT]     = (oc_state_ff == rfp_pkg::RFP_OC_SHUT);
        status_word[`RFP_ST_TWO_PHASE]   = two_ff;
        status_word[`RFP_ST_INIT_OFS]    = init_ofs_ff;
        status_word[`RFP_ST_EXT_OFS]     = ext_ofs_ff;
        status_word[`RFP_ST_COMP_LO+1 -: 2] = comp_ff;
    end

    assign nxt_rdata = (AVS_ADDRESS == `RFP_REG_TRIP_DELAY) ? 32'(trip_delay_ff)
                     : (AVS_ADDRESS == `RFP_REG_ACT_DELAY)  ? 32'(act_delay_ff)
                     : (AVS_ADDRESS == `RFP_REG_STATUS)     ? status_word
                     : (AVS_ADDRESS == `RFP_REG_CURRENT)    ? {23'h000000, code_ff}
                     : 32'h0000_0000;

    // Read data loaded as waitrequest drops
    always_ff @(posedge CLK)
    begin
        if (RESET)
            rdata_ff <= 32'h0000_0000;
        else if (AVS_READ && wait_ff)
            rdata_ff <= nxt_rdata;
    end

    logic flag_n_ff; // Over-current flag, active low
    logic shut_other_ff; // Other rail shutdown request

    // Flag and cross-rail shutdown registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            flag_n_ff     <= 1'b1;
            shut_other_ff <= 1'b0;
        end
        else
        begin
            flag_n_ff     <= (nxt_oc_state == rfp_pkg::RFP_OC_IDLE);
            shut_other_ff <= ov_ff || uv_ff;
        end
    end

    assign AVS_READDATA        = rdata_ff;
    assign AVS_WAITREQUEST     = wait_ff;
    assign HIGH_SIDE_ON        = hs_ff;
    assign LOW_SIDE_ON         = ls_ff;
    assign OVERCURRENT_FLAG_N  = flag_n_ff;
    assign OTHER_RAIL_SHUTDOWN = shut_other_ff;
    assign TWO_PHASE_FORCE     = two_ff;
    assign INIT_OFFSET_EN      = init_ofs_ff;
    assign EXT_OFFSET_EN       = ext_ofs_ff;
    assign STEP_COMP_SEL       = comp_ff;

endmodule

// >>> include/rfp_cfg.svh
/*
 * Holds offsets, field positions, reset values and timing counts.
 * Assumes a 10 MHz clock.
 */
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH

// ----------------------------------------------------------------------
// Clock and delays
// ----------------------------------------------------------------------
`define RFP_CLK_HZ          10000000
`define RFP_OV_DELAY_NS     1000
`define RFP_UV_DELAY_NS     3000
`define RFP_LOCK_DELAY_NS   3000
`define RFP_OV_CYCLES       ((`RFP_OV_DELAY_NS * (`RFP_CLK_HZ / 1000000) + 999) / 1000)
`define RFP_UV_CYCLES       ((`RFP_UV_DELAY_NS * (`RFP_CLK_HZ / 1000000) + 999) / 1000)
`define RFP_LOCK_CYCLES     ((`RFP_LOCK_DELAY_NS * (`RFP_CLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RFP_REG_TRIP_DELAY  4'h0
`define RFP_REG_ACT_DELAY   4'h4
`define RFP_REG_STATUS      4'h8
`define RFP_REG_CURRENT     4'hc

// ----------------------------------------------------------------------
// Reset values and status field positions
// ----------------------------------------------------------------------
`define RFP_TRIP_DELAY_RST  16'h0064
`define RFP_ACT_DELAY_RST   16'h0032
`define RFP_ST_OV           0
`define RFP_ST_UV           1
`define RFP_ST_NEG          2
`define RFP_ST_LOCK         3
`define RFP_ST_OC_FLAG      4
`define RFP_ST_OC_SHUT      5
`define RFP_ST_TWO_PHASE    6
`define RFP_ST_INIT_OFS     7
`define RFP_ST_EXT_OFS      8
`define RFP_ST_COMP_LO      9

// ----------------------------------------------------------------------
// Current report converter
// ----------------------------------------------------------------------
`define RFP_ADC_STEP_UV     6250
`define RFP_ADC_MAX_CODE    9'h1ff

`endif

// >>> include/rfp_pkg.sv
/*
 * Holds the types shared by the rail fault protection files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rfp_pkg;

    // Over-current supervisor states
    typedef enum logic [2:0]
    {
        RFP_OC_IDLE  = 3'b001,
        RFP_OC_DELAY = 3'b010,
        RFP_OC_SHUT  = 3'b100
    } rfp_oc_state_t;

endpackage

// >>> logic/rfp_deglitch.sv
/*
 * Holds a persistence filter: hit once cond has held limit cycles.
 * Assumes synchronous reset and input.
 */
`timescale 1ns/1ps

module rfp_deglitch
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Condition and its required duration
    input  wire logic             cond,
    input  wire logic [WIDTH-1:0] limit,
    // Filtered condition
    output logic                  hit
);

    initial
    begin
        if (WIDTH < 2)
            $error("WIDTH must be at least 2");
    end

    logic [WIDTH-1:0] cnt_ff;       // Cycles the condition has held
    logic [WIDTH-1:0] nxt_cnt;      // Next count
    logic             full;         // Count has reached the limit

    assign full    = (cnt_ff >= limit);
    // A drop restarts the count
    assign nxt_cnt = !cond ? '0 : (full ? cnt_ff : cnt_ff + 1'b1);
    assign hit     = cond && full;

    // Count register
    always_ff @(posedge clk)
    begin
        if (reset)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

endmodule

// >>> test/rfp_power_stage.sv
/* Power stage model: period of eight cycles, three on.
   Assumes the block's CLK and RESET. */
`timescale 1ns/1ps
module rfp_power_stage #(parameter int PHASES = 2)
(
    // Clock and reset
    input  wire logic         CLK, RESET,
    // Switching pattern
    output logic [PHASES-1:0] PWM_HIGH, PWM_LOW,
    output logic              SWITCH_CYCLE_STROBE, ONTIME_REF
);
    logic [2:0] pos_ff; // Place in the period
    always_ff @(posedge CLK)
        pos_ff <= RESET ? 3'h0 : pos_ff + 3'h1;
    assign ONTIME_REF          = pos_ff < 3'h3;
    assign SWITCH_CYCLE_STROBE = pos_ff == 3'h0;
    assign PWM_HIGH            = {PHASES{ONTIME_REF}};
    assign PWM_LOW             = ~PWM_HIGH;
endmodule

// >>> test/rfp_rail_protect_props.sv
/* Port checker of the rail protection block.
   Assumes a bind onto rfp_rail_protect. */
`timescale 1ns/1ps
module rfp_props #(parameter int PHASES = 2)
(
    input wire logic CLK, RESET, ENABLE, SUPPLY_ABOVE_POR, STEP_UP, TWO_PHASE_FORCE, EXT_OFFSET_EN,
    input wire logic PEAK_CURRENT_ABOVE, SWITCH_CYCLE_STROBE, OVERCURRENT_FLAG_N, OTHER_RAIL_SHUTDOWN,
    input wire logic VOLTAGE_CODE_BELOW_LIMIT, RAIL_SENSE_ABOVE_FIXED, FAST_LOAD_TRIGGER,
    input wire logic [1:0] CONFIG_STRAP_ONE, CONFIG_STRAP_TWO, STEP_COMP_SEL,
    input wire logic [PHASES-1:0] PHASE_ACTIVE, HIGH_SIDE_ON, LOW_SIDE_ON
);
    logic [5:0] low_ff, ov_ff; // Run lengths
    wire ov = ENABLE && SUPPLY_ABOVE_POR && VOLTAGE_CODE_BELOW_LIMIT && RAIL_SENSE_ABOVE_FIXED;
    // Saturating run counters
    always_ff @(posedge CLK)
    begin
        low_ff <= (RESET || SUPPLY_ABOVE_POR) ? 6'h0 : low_ff + {5'h0, low_ff != 6'h3f};
        ov_ff  <= (RESET || !ov) ? 6'h0 : ov_ff + {5'h0, ov_ff != 6'h3f};
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_strap_offset: assert property (!$past(RESET) && $stable(CONFIG_STRAP_TWO)
        |-> EXT_OFFSET_EN == CONFIG_STRAP_TWO[0]) else $error("offset");
    a_strap_comp: assert property (!$past(RESET) && $stable({CONFIG_STRAP_ONE, CONFIG_STRAP_TWO})
        |-> STEP_COMP_SEL == {CONFIG_STRAP_ONE[1], CONFIG_STRAP_TWO[1]}) else $error("comp");
    a_step_two: assert property (STEP_UP |-> ##[1:3] TWO_PHASE_FORCE) else $error("phase");
    a_peak_flag: assert property (PEAK_CURRENT_ABOVE && SWITCH_CYCLE_STROBE |-> ##[1:3] !OVERCURRENT_FLAG_N)
        else $error("flag");
    a_lock_off: assert property (low_ff == 6'h22 |-> !(HIGH_SIDE_ON | LOW_SIDE_ON)) else $error("lock");
    a_ov_latch: assert property (ov_ff == 6'h0e |-> OTHER_RAIL_SHUTDOWN && !HIGH_SIDE_ON) else $error("ov");
    a_latch_hold: assert property ((!ENABLE) [*3] ##0 OTHER_RAIL_SHUTDOWN |=> OTHER_RAIL_SHUTDOWN)
        else $error("hold");
    a_fast_pulse: assert property ($rose(FAST_LOAD_TRIGGER) && OVERCURRENT_FLAG_N && !OTHER_RAIL_SHUTDOWN
        |-> ##[1:3] (HIGH_SIDE_ON & PHASE_ACTIVE) == PHASE_ACTIVE) else $error("pulse");
endmodule

// >>> test/rfp_rail_protect_tb_top.sv
/* Bench of the rail protection block with its power stage.
   Assumes design, model and checker compiled first. */
`timescale 1ns/1ps
module rfp_rail_protect_tb_top;
    logic CLK = '0, RESET = '1, AVS_READ = '0, AVS_WRITE = '0, ENABLE = '0, SUPPLY_ABOVE_POR = '1;
    logic EXTERNAL_OFFSET_INPUT_LOW = '0, VOLTAGE_CODE_BELOW_LIMIT = '1, RAIL_SENSE_ABOVE_FIXED = '0;
    logic RAIL_SENSE_ABOVE_REF = '0, RAIL_SENSE_BELOW_REF = '0, RAIL_SENSE_NEGATIVE = '0, STEP_UP = '0;
    logic SUSTAINED_CURRENT_ABOVE = '0, PEAK_CURRENT_ABOVE = '0, STEP_DOWN = '0, PHASE_SHED_REQ = '0;
    logic FAST_LOAD_TRIGGER = '0, AVS_WAITREQUEST, OVERCURRENT_FLAG_N, OTHER_RAIL_SHUTDOWN, TWO_PHASE_FORCE;
    logic INIT_OFFSET_EN, EXT_OFFSET_EN, SWITCH_CYCLE_STROBE, ONTIME_REF;
    logic [3:0]  AVS_ADDRESS = '0;
    logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, q;
    logic [21:0] CURRENT_MONITOR_UV = '0;
    logic [1:0]  CONFIG_STRAP_ONE = '0, CONFIG_STRAP_TWO = '0, PHASE_ACTIVE = '1, STEP_COMP_SEL;
    logic [1:0]  PWM_HIGH, PWM_LOW, HIGH_SIDE_ON, LOW_SIDE_ON;
    logic [21:0] uv [4] = '{22'h1869, 22'h186a, 22'h30bb95, 22'h3fffff}; // Monitor samples
    logic [31:0] cd [4] = '{32'h0, 32'h1, 32'h1fe, 32'h1ff}; // Their codes
    int          errors = 0, tests_run = 0, cycles = 0;
    rfp_rail_protect rfp_rail_protect_inst (.*);
    rfp_power_stage rfp_power_stage_inst (.*);
    always #50 CLK = ~CLK;
    // Hang guard
    always @(posedge CLK)
        if (++cycles == 3000)
        begin
            errors++;
            results();
        end
    task tick(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access, held until waitrequest low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= '0;
        AVS_READ <= '0;
        @(posedge CLK);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp);
        bus('0, a, '0);
        chk(q, exp);
    endtask
    task results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        tick(2);
        RESET <= '0;
        ENABLE <= '1;
        tick(3);
        chk(INIT_OFFSET_EN, 1);
        rd(4'h0, 32'h64);
        rd(4'h4, 32'h32);
        rd(4'h2, 32'h0);
        bus('1, 4'h0, 32'h3);
        bus('1, 4'h4, 32'h2);
        bus('1, 4'hc, 32'h7);
        rd(4'h4, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            CURRENT_MONITOR_UV <= uv[i];
            tick(3);
            rd(4'hc, cd[i]);
        end
        $display("registers done");
        for (int i = 0; i < 4; i++)
        begin
            CONFIG_STRAP_ONE <= {i[1], 1'b0};
            CONFIG_STRAP_TWO <= {2{i[0]}};
            tick(3);
            chk(EXT_OFFSET_EN, i[0]);
            chk(STEP_COMP_SEL, i[1:0]);
        end
        STEP_UP <= '1;
        tick(1);
        STEP_UP <= '0;
        STEP_DOWN <= '1;
        FAST_LOAD_TRIGGER <= '1;
        tick(4);
        chk(TWO_PHASE_FORCE, 1);
        {STEP_DOWN, FAST_LOAD_TRIGGER, PEAK_CURRENT_ABOVE} <= 3'h1;
        tick(10);
        chk(OVERCURRENT_FLAG_N, 0);
        tick(6);
        chk({HIGH_SIDE_ON, LOW_SIDE_ON}, 0);
        {PEAK_CURRENT_ABOVE, ENABLE} <= 2'h0;
        tick(1);
        ENABLE <= '1;
        RAIL_SENSE_ABOVE_FIXED <= '1;
        tick(9);
        RAIL_SENSE_ABOVE_FIXED <= '0;
        tick(4);
        chk({OVERCURRENT_FLAG_N, OTHER_RAIL_SHUTDOWN}, 2'h2);
        {VOLTAGE_CODE_BELOW_LIMIT, RAIL_SENSE_ABOVE_REF} <= 2'h1;
        tick(15);
        chk({OTHER_RAIL_SHUTDOWN, HIGH_SIDE_ON, LOW_SIDE_ON}, 5'h13);
        {VOLTAGE_CODE_BELOW_LIMIT, RAIL_SENSE_ABOVE_REF, RAIL_SENSE_NEGATIVE} <= 3'h5;
        tick(3);
        chk(LOW_SIDE_ON, 0);
        RAIL_SENSE_NEGATIVE <= '0;
        tick(3);
        chk(LOW_SIDE_ON, 3);
        {EXTERNAL_OFFSET_INPUT_LOW, ENABLE} <= 2'h2;
        tick(1);
        ENABLE <= '1;
        tick(3);
        chk({OTHER_RAIL_SHUTDOWN, INIT_OFFSET_EN}, 0);
        {SUPPLY_ABOVE_POR, RAIL_SENSE_ABOVE_FIXED} <= 2'h1;
        tick(35);
        chk({HIGH_SIDE_ON, LOW_SIDE_ON}, 0);
        {SUPPLY_ABOVE_POR, RAIL_SENSE_ABOVE_FIXED} <= 2'h2;
        tick(3);
        chk(OTHER_RAIL_SHUTDOWN, 0);
        RAIL_SENSE_BELOW_REF <= '1;
        tick(33);
        chk({OTHER_RAIL_SHUTDOWN, HIGH_SIDE_ON, LOW_SIDE_ON}, 5'h10);
        $display("protection done");
        results();
    end
endmodule
bind rfp_rail_protect rfp_props #(.PHASES(PHASES)) rfp_props_inst (.*);
